/* rtl/sbc_dev.sv */
// DRAM end: alternate-bank command handling and clock-enable states
// Contract
// - Inhibit or no-op keeps operations running
// - Idle tracked bank allows other-bank commands
// - Busy bank still allows supported other-bank commands
// - Refresh and mode load need all idle
// - Burst terminate hits only bursting bank
// - Interrupted auto-precharge burst starts precharge
// - Other-bank precharge leaves burst running
// - Read interrupt swaps data one latency later
// - Write cuts plain read at registration
// - Read cuts write; last word before it
// - Write cuts write; last word before it
// - Read cuts auto-precharge read; precharge now
// - Write cuts auto-precharge read; precharge now
// - Read cuts auto-precharge write; recovery first
// - Write cuts auto-precharge write; recovery first
// - Active after activate-to-access time
// - Auto-precharge bank busy until precharge done
// - Clock-enable low twice holds low-power state
// - Power-down entry and exit on no-op
// - Power-down exit idle, next edge accepted
// - Self-refresh exit waits exit time, no-ops
// - Clock suspend during burst, resume next edge
// - Refresh with enable low enters self refresh
`timescale 1ns/1ns
module sbc_dev #(
	parameter int RL = sbc_pkg::READ_LATENCY,
	parameter int BL = sbc_pkg::BURST_LEN
) (
	// Link pins
	sbc_if.dev lnk,
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Observed state
	output logic [35:0] bank_state,
	output sbc_pkg::sbc_pw_t power_state,
	output logic cmd_err,
	// Accepted write words
	output logic wr_acc,
	output logic [1:0] wr_bank,
	output logic [7:0] wr_word
);
	import sbc_pkg::*;

	logic [17:0] pin_s1, pin_s2;
	logic clk_d, edge_hit, adv, exec, all_idle;
	logic [3:0] cmd;
	logic [1:0] s_ba;
	sbc_bank_t bank_st [4], next_st [4];
	logic [7:0] bank_tmr [4], next_tmr [4];
	sbc_pw_t next_pw;
	logic cke_prev, next_cke_prev;
	logic bst_on, next_bst_on, bst_rd, next_bst_rd;
	logic [1:0] bst_bank, next_bst_bank;
	logic [3:0] bst_left, next_bst_left;
	logic pipe_v [RL], next_pipe_v [RL];
	logic [7:0] pipe_d [RL], next_pipe_d [RL];
	logic [7:0] xsr_tmr, next_xsr_tmr;
	logic [7:0] dq_o, next_dq_o;
	logic dq_oe, next_dq_oe;
	logic next_cmd_err, next_wr_acc;
	logic [1:0] next_wr_bank;
	logic [7:0] next_wr_word;

	// State a bank takes when its burst ends or is cut
	function automatic sbc_bank_t after_burst(input sbc_bank_t s);
		case (s)
			BK_READ_AP: return BK_PRECHARGING;
			BK_WRITE_AP: return BK_WR_RECOV;
			default: return BK_ACTIVE;
		endcase
	endfunction : after_burst

	// Timer loaded with that state
	function automatic logic [7:0] after_tmr(input sbc_bank_t s);
		return (s == BK_WRITE_AP) ? 8'(WR_CLK) : 8'(RP_CYC);
	endfunction : after_tmr

	// Two-stage pin synchroniser
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1 <= 18'h00000;
			pin_s2 <= 18'h00000;
			clk_d <= 1'b0;
		end else begin
			pin_s1 <= {lnk.sd_clk, lnk.cke, lnk.cs_n, lnk.ras_n, lnk.cas_n,
				lnk.we_n, lnk.ba, lnk.ap, lnk.dqm, lnk.dq};
			pin_s2 <= pin_s1;
			clk_d <= pin_s2[17];
		end
	end

	// Link edge, command decode and execution enables
	assign edge_hit = pin_s2[17] & ~clk_d;
	assign cmd = pin_s2[15] ? CMD_INH : {1'b0, pin_s2[14:12]};
	assign s_ba = pin_s2[11:10];
	assign adv = edge_hit && power_state == PW_RUN && pin_s2[16];
	assign exec = edge_hit && power_state == PW_RUN && cke_prev;
	assign all_idle = bank_st[0] == BK_IDLE && bank_st[1] == BK_IDLE &&
		bank_st[2] == BK_IDLE && bank_st[3] == BK_IDLE;
	assign lnk.dev_dq_o = dq_o;
	assign lnk.dev_dq_oe = dq_oe;

	// Bank state outputs
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			bank_state[b*9 +: 9] = bank_st[b];
		end
	end

	// Next state of banks, burst, pipeline and power
	always_comb begin
		next_st = bank_st;
		next_tmr = bank_tmr;
		next_pw = power_state;
		next_cke_prev = cke_prev;
		next_bst_on = bst_on;
		next_bst_rd = bst_rd;
		next_bst_bank = bst_bank;
		next_bst_left = bst_left;
		next_pipe_v = pipe_v;
		next_pipe_d = pipe_d;
		next_xsr_tmr = xsr_tmr;
		next_dq_o = dq_o;
		next_dq_oe = dq_oe;
		next_cmd_err = 1'b0;
		next_wr_acc = 1'b0;
		next_wr_bank = wr_bank;
		next_wr_word = wr_word;
		// Bank timers; recovery counts link edges
		for (int b = 0; b < 4; b++) begin
			if (bank_tmr[b] != 8'h00) begin
				if (bank_st[b] != BK_WR_RECOV || edge_hit)
					next_tmr[b] = bank_tmr[b] - 8'h01;
			end else begin
				case (bank_st[b])
					BK_ACTIVATING: next_st[b] = BK_ACTIVE;
					BK_PRECHARGING: next_st[b] = BK_IDLE;
					BK_WR_RECOV: begin
						next_st[b] = BK_PRECHARGING;
						next_tmr[b] = 8'(RP_CYC);
					end
					default: ;
				endcase
			end
		end
		// Self-refresh exit wait
		if (xsr_tmr != 8'h00)
			next_xsr_tmr = xsr_tmr - 8'h01;
		else if (power_state == PW_SREX)
			next_pw = PW_RUN;
		// Clock-enable sampling per link edge
		if (edge_hit) begin
			next_cke_prev = pin_s2[16];
			case (power_state)
				PW_RUN: begin
					if (cke_prev && !pin_s2[16]) begin
						if (all_idle && sbc_is_nop(cmd))
							next_pw = PW_PDOWN;
						else if (all_idle && cmd == CMD_REF)
							next_pw = PW_SREF;
						else if (bst_on)
							next_pw = PW_SUSP;
						else
							next_cmd_err = 1'b1;
					end
				end
				PW_PDOWN, PW_SREF: begin
					if (pin_s2[16]) begin
						next_pw = (power_state == PW_PDOWN) ? PW_RUN : PW_SREX;
						next_xsr_tmr = 8'(XSR_CYC);
						if (!sbc_is_nop(cmd))
							next_cmd_err = 1'b1;
					end
				end
				PW_SREX: begin
					if (!sbc_is_nop(cmd))
						next_cmd_err = 1'b1;
				end
				PW_SUSP: begin
					if (pin_s2[16])
						next_pw = PW_RUN;
				end
				default: next_pw = PW_RUN;
			endcase
		end
		// Burst beat of the running burst
		if (adv) begin
			next_dq_o = pipe_d[RL-1];
			next_dq_oe = pipe_v[RL-1] & ~pin_s2[8];
			for (int i = RL - 1; i > 0; i--) begin
				next_pipe_v[i] = pipe_v[i-1];
				next_pipe_d[i] = pipe_d[i-1];
			end
			next_pipe_v[0] = 1'b0;
			if (bst_on) begin
				if (bst_rd) begin
					next_pipe_v[0] = 1'b1;
					next_pipe_d[0] = {bst_bank, 2'b00, 4'(BL) - bst_left};
				end else if (!pin_s2[8]) begin
					next_wr_acc = 1'b1;
					next_wr_bank = bst_bank;
					next_wr_word = pin_s2[7:0];
				end
				if (bst_left == 4'h1) begin
					next_bst_on = 1'b0;
					next_st[bst_bank] = after_burst(bank_st[bst_bank]);
					next_tmr[bst_bank] = after_tmr(bank_st[bst_bank]);
				end
				next_bst_left = bst_left - 4'h1;
			end
		end
		// Command registered at this edge; inhibit and no-op fall through
		if (exec) begin
			case (cmd)
				CMD_ACT: begin
					if (bank_st[s_ba] == BK_IDLE) begin
						next_st[s_ba] = BK_ACTIVATING;
						next_tmr[s_ba] = 8'(RCD_CYC);
					end else
						next_cmd_err = 1'b1;
				end
				CMD_RD, CMD_WR: begin
					if (bank_st[s_ba] inside {BK_ACTIVE, BK_READ, BK_WRITE}) begin
						if (bst_on && bst_bank != s_ba) begin
							next_st[bst_bank] = after_burst(bank_st[bst_bank]);
							next_tmr[bst_bank] = after_tmr(bank_st[bst_bank]);
						end
						next_bst_on = 1'b1;
						next_bst_rd = cmd[0];
						next_bst_bank = s_ba;
						next_bst_left = 4'(BL - 1);
						if (cmd[0]) begin
							next_st[s_ba] = pin_s2[9] ? BK_READ_AP : BK_READ;
							next_pipe_v[0] = 1'b1;
							next_pipe_d[0] = {s_ba, 6'h00};
							next_wr_acc = 1'b0;
						end else begin
							next_st[s_ba] = pin_s2[9] ? BK_WRITE_AP : BK_WRITE;
							for (int i = 0; i < RL; i++) begin
								next_pipe_v[i] = 1'b0;
							end
							next_dq_oe = 1'b0;
							next_wr_acc = ~pin_s2[8];
							next_wr_bank = s_ba;
							next_wr_word = pin_s2[7:0];
						end
					end else
						next_cmd_err = 1'b1;
				end
				CMD_PRE: begin
					if (bank_st[s_ba] inside {BK_ACTIVE, BK_READ, BK_WRITE}) begin
						next_st[s_ba] = BK_PRECHARGING;
						next_tmr[s_ba] = 8'(RP_CYC);
						if (bst_on && bst_bank == s_ba)
							next_bst_on = 1'b0;
					end else if (bank_st[s_ba] != BK_IDLE)
						next_cmd_err = 1'b1;
				end
				CMD_BST: begin
					if (bst_on) begin
						next_bst_on = 1'b0;
						next_st[bst_bank] = after_burst(bank_st[bst_bank]);
						next_tmr[bst_bank] = after_tmr(bank_st[bst_bank]);
					end else
						next_cmd_err = 1'b1;
				end
				CMD_REF, CMD_LMR: begin
					if (!all_idle)
						next_cmd_err = 1'b1;
				end
				default: ;
			endcase
		end
	end

	// Registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bank_st <= '{default: BK_IDLE};
			bank_tmr <= '{default: 8'h00};
			power_state <= PW_RUN;
			cke_prev <= 1'b1;
			bst_on <= 1'b0;
			bst_rd <= 1'b0;
			bst_bank <= 2'h0;
			bst_left <= 4'h0;
			pipe_v <= '{default: 1'b0};
			pipe_d <= '{default: 8'h00};
			xsr_tmr <= 8'h00;
			dq_o <= 8'h00;
			dq_oe <= 1'b0;
			cmd_err <= 1'b0;
			wr_acc <= 1'b0;
			wr_bank <= 2'h0;
			wr_word <= 8'h00;
		end else begin
			bank_st <= next_st;
			bank_tmr <= next_tmr;
			power_state <= next_pw;
			cke_prev <= next_cke_prev;
			bst_on <= next_bst_on;
			bst_rd <= next_bst_rd;
			bst_bank <= next_bst_bank;
			bst_left <= next_bst_left;
			pipe_v <= next_pipe_v;
			pipe_d <= next_pipe_d;
			xsr_tmr <= next_xsr_tmr;
			dq_o <= next_dq_o;
			dq_oe <= next_dq_oe;
			cmd_err <= next_cmd_err;
			wr_acc <= next_wr_acc;
			wr_bank <= next_wr_bank;
			wr_word <= next_wr_word;
		end
	end
endmodule : sbc_dev

/* rtl/sbc_pkg.sv */
// Shared constants, commands and state types for the DRAM command model
package sbc_pkg;
	// System clock and link timing
	localparam int CLK_NS = 10;
	localparam int LINK_HALF = 8;
	localparam int LINK_NS = 2 * LINK_HALF * CLK_NS;
	localparam int T_RP_NS = 20;
	localparam int T_RCD_NS = 20;
	localparam int T_XSR_NS = 75;
	localparam int WR_CLK = 2;
	localparam int READ_LATENCY = 3;
	localparam int BURST_LEN = 4;
	// Counts in system clocks, rounded up
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
	localparam int XSR_CYC = (T_XSR_NS + CLK_NS - 1) / CLK_NS;
	// Counts in link clocks, rounded up
	localparam int RP_LNK = (T_RP_NS + LINK_NS - 1) / LINK_NS;
	localparam int RCD_LNK = (T_RCD_NS + LINK_NS - 1) / LINK_NS;
	localparam int XSR_RAW = (T_XSR_NS + LINK_NS - 1) / LINK_NS;
	localparam int XSR_LNK = (XSR_RAW < 2) ? 2 : XSR_RAW;
	// Command codes: {chip select, row, column, write strobe}
	localparam logic [3:0] CMD_LMR = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_BST = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_INH = 4'h8;
	// Device bank states
	typedef enum logic [8:0] {
		BK_IDLE = 9'h001,
		BK_ACTIVATING = 9'h002,
		BK_ACTIVE = 9'h004,
		BK_READ = 9'h008,
		BK_WRITE = 9'h010,
		BK_READ_AP = 9'h020,
		BK_WRITE_AP = 9'h040,
		BK_WR_RECOV = 9'h080,
		BK_PRECHARGING = 9'h100
	} sbc_bank_t;
	// Device power states
	typedef enum logic [4:0] {
		PW_RUN = 5'h01,
		PW_PDOWN = 5'h02,
		PW_SREF = 5'h04,
		PW_SREX = 5'h08,
		PW_SUSP = 5'h10
	} sbc_pw_t;
	// Controller view of a bank
	typedef enum logic [2:0] {
		CB_IDLE = 3'h1,
		CB_OPEN = 3'h2,
		CB_BUSY = 3'h4
	} sbc_cb_t;

	// Inhibit or no-operation
	function automatic logic sbc_is_nop(input logic [3:0] c);
		return c[3] | (c == CMD_NOP);
	endfunction : sbc_is_nop
endpackage : sbc_pkg

/* rtl/sbc_if.sv */
// Command, clock-enable and data pins between controller and DRAM
`timescale 1ns/1ns
interface sbc_if;
	logic sd_clk;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic ap;
	logic dqm;
	logic [7:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [7:0] dev_dq_o;
	logic dev_dq_oe;
	logic [7:0] dq;

	// Data wire level from the two enables
	assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 8'h00);

	modport ctl (output sd_clk, cke, cs_n, ras_n, cas_n, we_n, ba, ap, dqm,
		output ctl_dq_o, ctl_dq_oe, input dq);
	modport dev (input sd_clk, cke, cs_n, ras_n, cas_n, we_n, ba, ap, dqm,
		input dq, output dev_dq_o, dev_dq_oe);
endinterface : sbc_if

/* rtl/sbc_ctl.sv */
// Controller end: link clock, legal command issue and read capture
`timescale 1ns/1ns
module sbc_ctl #(
	parameter int RL = sbc_pkg::READ_LATENCY,
	parameter int BL = sbc_pkg::BURST_LEN
) (
	// Link pins
	sbc_if.ctl lnk,
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Command request
	input wire logic req_valid,
	input wire logic [3:0] req_cmd,
	input wire logic [1:0] req_bank,
	input wire logic req_ap,
	input wire logic req_cke,
	input wire logic [7:0] req_wdata,
	output logic req_ready,
	output logic req_err,
	// Read return
	output logic rd_valid,
	output logic [7:0] rd_data
);
	import sbc_pkg::*;

	logic [7:0] div_cnt, next_div;
	logic sclk, next_sclk, fall, legal, take, waiting, rd_pend, all_idle;
	logic [3:0] cmd, next_cmd;
	logic [1:0] ba, next_ba, lead, next_lead, need;
	logic ap, next_ap, dqm, next_dqm, cke, next_cke;
	logic [7:0] dq_o, next_dq_o, dq_s1, dq_s2;
	sbc_cb_t cb_st [4], next_cb [4], cb_to [4], next_to [4];
	logic [7:0] cb_tmr [4], next_tmr [4];
	logic b_on, next_b_on, b_rd, next_b_rd, b_ap, next_b_ap;
	logic [1:0] b_bank, next_b_bank;
	logic [3:0] b_left, next_b_left;
	logic sr, next_sr;
	logic [7:0] xsr, next_xsr;
	logic [RL:0] rpipe, next_rpipe;
	logic next_rd_valid;
	logic [7:0] next_rd_data;

	// Pins and link clock divider outputs
	assign lnk.sd_clk = sclk;
	assign {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} = cmd;
	assign lnk.ba = ba;
	assign lnk.ap = ap;
	assign lnk.dqm = dqm;
	assign lnk.cke = cke;
	assign lnk.ctl_dq_o = dq_o;
	assign lnk.ctl_dq_oe = b_on & ~b_rd;
	assign fall = (div_cnt == 8'(LINK_HALF - 1)) && sclk;

	// Legality against the tracked bank states
	always_comb begin
		all_idle = 1'b1;
		for (int b = 0; b < 4; b++) begin
			if (cb_st[b] != CB_IDLE)
				all_idle = 1'b0;
		end
		case (req_cmd)
			CMD_ACT: legal = cb_st[req_bank] == CB_IDLE;
			CMD_RD, CMD_WR: legal = cb_st[req_bank] == CB_OPEN;
			CMD_PRE: legal = cb_st[req_bank] != CB_BUSY;
			CMD_BST: legal = b_on;
			CMD_REF, CMD_LMR: legal = all_idle;
			default: legal = 1'b1;
		endcase
		if ((sr || !cke || xsr != 8'h00) && !(sbc_is_nop(req_cmd) ||
				(!cke && !sr && req_cmd == CMD_REF && !req_cke)))
			legal = 1'b0;
		if (sr && xsr == 8'h00 && !cke && !req_cke && !sbc_is_nop(req_cmd))
			legal = 1'b0;
		rd_pend = (b_on && b_rd) || (rpipe != '0);
		need = (req_cmd == CMD_WR && rd_pend) ? (b_ap ? 2'h2 : 2'h1) : 2'h0;
		waiting = req_valid && legal && lead < need;
		take = fall && req_valid && !waiting;
		req_ready = take;
		req_err = take && !legal;
	end

	// Next values of link pins, bank tracking and capture
	always_comb begin
		next_div = (div_cnt == 8'(LINK_HALF - 1)) ? 8'h00 : div_cnt + 8'h01;
		next_sclk = (div_cnt == 8'(LINK_HALF - 1)) ? ~sclk : sclk;
		next_cmd = cmd;
		next_ba = ba;
		next_ap = ap;
		next_dqm = dqm;
		next_cke = cke;
		next_dq_o = dq_o;
		next_lead = lead;
		next_cb = cb_st;
		next_to = cb_to;
		next_tmr = cb_tmr;
		next_b_on = b_on;
		next_b_rd = b_rd;
		next_b_ap = b_ap;
		next_b_bank = b_bank;
		next_b_left = b_left;
		next_sr = sr;
		next_xsr = xsr;
		next_rpipe = rpipe;
		next_rd_valid = 1'b0;
		next_rd_data = rd_data;
		if (fall) begin
			next_rd_valid = rpipe[RL];
			next_rd_data = dq_s2;
			next_cmd = CMD_NOP;
			next_dqm = waiting;
			next_lead = waiting ? lead + 2'h1 : 2'h0;
			if (xsr != 8'h00)
				next_xsr = xsr - 8'h01;
			// Bank frees on the fall where its last timer count expires
			for (int b = 0; b < 4; b++) begin
				if (cb_tmr[b] > 8'h01 && !(b_on && b_ap && b_bank == 2'(b)))
					next_tmr[b] = cb_tmr[b] - 8'h01;
				else if (cb_st[b] == CB_BUSY &&
						!(b_on && b_ap && b_bank == 2'(b))) begin
					next_tmr[b] = 8'h00;
					next_cb[b] = cb_to[b];
				end
			end
			if (take && legal) begin
				next_cmd = req_cmd;
				next_ba = req_bank;
				next_ap = req_ap;
				next_cke = req_cke;
				if (sr && req_cke) begin
					next_sr = 1'b0;
					next_xsr = 8'(XSR_LNK);
				end
				case (req_cmd)
					CMD_REF: next_sr = cke && !req_cke;
					CMD_ACT: begin
						next_cb[req_bank] = CB_BUSY;
						next_to[req_bank] = CB_OPEN;
						next_tmr[req_bank] = 8'(RCD_LNK);
					end
					CMD_PRE: begin
						next_cb[req_bank] = CB_BUSY;
						next_to[req_bank] = CB_IDLE;
						next_tmr[req_bank] = 8'(RP_LNK);
						if (b_on && b_bank == req_bank)
							next_b_on = 1'b0;
					end
					CMD_BST: next_b_on = 1'b0;
					CMD_RD, CMD_WR: begin
						if (b_on && b_ap && b_bank != req_bank)
							next_tmr[b_bank] = 8'(b_rd ? RP_LNK : RP_LNK + WR_CLK);
						next_b_on = 1'b1;
						next_b_rd = req_cmd[0];
						next_b_ap = req_ap;
						next_b_bank = req_bank;
						next_b_left = 4'(BL);
						next_dq_o = req_wdata;
						if (req_ap) begin
							next_cb[req_bank] = CB_BUSY;
							next_to[req_bank] = CB_IDLE;
							next_tmr[req_bank] = 8'(req_cmd[0] ? RP_LNK : RP_LNK + WR_CLK);
						end
						if (!req_cmd[0])
							next_rpipe = '0;
					end
					default: ;
				endcase
			end
			// Beat count advances only while the enable is high
			if (next_b_on && next_cke) begin
				next_b_left = next_b_left - 4'h1;
				if (next_b_left == 4'h1)
					next_b_on = 1'b0;
			end
			next_rpipe = {next_rpipe[RL-1:0],
				next_b_on_beat(next_b_left, next_b_on && next_b_rd)};
			if (!next_cke)
				next_rpipe = rpipe;
		end
	end

	// Beat flag for the capture pipeline
	function automatic logic next_b_on_beat(input logic [3:0] l, input logic o);
		return o && (l != 4'h0);
	endfunction : next_b_on_beat

	// Registers and data-pin synchroniser
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 8'h00;
			sclk <= 1'b0;
			cmd <= CMD_INH;
			ba <= 2'h0;
			ap <= 1'b0;
			dqm <= 1'b0;
			cke <= 1'b1;
			dq_o <= 8'h00;
			lead <= 2'h0;
			cb_st <= '{default: CB_IDLE};
			cb_to <= '{default: CB_IDLE};
			cb_tmr <= '{default: 8'h00};
			b_on <= 1'b0;
			b_rd <= 1'b0;
			b_ap <= 1'b0;
			b_bank <= 2'h0;
			b_left <= 4'h0;
			sr <= 1'b0;
			xsr <= 8'h00;
			rpipe <= '0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
		end else begin
			div_cnt <= next_div;
			sclk <= next_sclk;
			cmd <= next_cmd;
			ba <= next_ba;
			ap <= next_ap;
			dqm <= next_dqm;
			cke <= next_cke;
			dq_o <= next_dq_o;
			lead <= next_lead;
			cb_st <= next_cb;
			cb_to <= next_to;
			cb_tmr <= next_tmr;
			b_on <= next_b_on && !(next_b_left == 4'h0);
			b_rd <= next_b_rd;
			b_ap <= next_b_ap;
			b_bank <= next_b_bank;
			b_left <= next_b_left;
			sr <= next_sr;
			xsr <= next_xsr;
			rpipe <= next_rpipe;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
			dq_s1 <= lnk.dq;
			dq_s2 <= dq_s1;
		end
	end
endmodule : sbc_ctl

/* dv/sbc_monitor.sv */
// Link-level assertions between the controller and DRAM ends
`timescale 1ns/1ns
module sbc_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Link clock and command pins
	input wire logic sd_clk,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic ap,
	// Data pins
	input wire logic ctl_dq_oe,
	input wire logic dev_dq_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Decoded commands on the pins
	wire rd_c = !cs_n && ras_n && !cas_n && we_n;
	wire wr_c = !cs_n && ras_n && !cas_n && !we_n;
	wire rf_c = !cs_n && !ras_n && !cas_n;

	a_no_contention: assert property (
		!(ctl_dq_oe && dev_dq_oe)) else $error("both ends drive data");
	a_pins_on_fall: assert property (
		$changed({cs_n, ras_n, cas_n, we_n, ba, ap}) |-> $fell(sd_clk))
		else $error("command pins moved off the link fall");
	a_cke_on_fall: assert property (
		$changed(cke) |-> $fell(sd_clk)) else $error("enable moved off fall");
	a_link_half: assert property (
		$rose(sd_clk) |-> sd_clk [*8] ##1 !sd_clk)
		else $error("link clock high time wrong");
	a_exit_nop: assert property (
		$rose(cke) |-> (cs_n || (ras_n && cas_n && we_n)))
		else $error("enable rose with a live command");
	a_read_answer: assert property (
		$rose(sd_clk) && rd_c && cke |-> ##[20:112] dev_dq_oe)
		else $error("read data never driven");
	a_write_data: assert property (
		$rose(sd_clk) && wr_c && cke |-> ##[0:16] ctl_dq_oe)
		else $error("write data never driven");
	a_refresh_quiet: assert property (
		$rose(sd_clk) && rf_c |-> !dev_dq_oe)
		else $error("refresh during a read burst");
endmodule : sbc_monitor

/* dv/sdram_bank_cke_command_fsm_tb.sv */
// Bench joining both ends, plus a rule-breaking driver on a second link
`timescale 1ns/1ns
module sdram_bank_cke_command_fsm_tb;
	import sbc_pkg::*;
	logic mclk, reset_n, req_valid, req_ap, req_cke, req_ready, req_err;
	logic rd_valid, cmd_err, wr_acc, cerr2, seen2;
	logic [3:0] req_cmd;
	logic [1:0] req_bank, wr_bank;
	logic [7:0] req_wdata, rd_data, wr_word;
	logic [35:0] bank_state;
	sbc_pw_t power_state;
	int errors, num_checks, n;
	int wcnt [4];
	sbc_if lnk ();
	sbc_if lnk2 ();
	sbc_ctl sbc_ctl_i (.lnk(lnk), .mclk, .reset_n, .req_valid, .req_cmd,
		.req_bank, .req_ap, .req_cke, .req_wdata, .req_ready, .req_err,
		.rd_valid, .rd_data);
	sbc_dev sbc_dev_i (.lnk(lnk), .mclk, .reset_n, .bank_state, .power_state,
		.cmd_err, .wr_acc, .wr_bank, .wr_word);
	sbc_dev sbc_dev_i2 (.lnk(lnk2), .mclk, .reset_n, .bank_state(),
		.power_state(), .cmd_err(cerr2), .wr_acc(), .wr_bank(), .wr_word());
	sbc_monitor sbc_monitor_i (.mclk, .reset_n, .sd_clk(lnk.sd_clk),
		.cke(lnk.cke), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n),
		.cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .ap(lnk.ap),
		.ctl_dq_oe(lnk.ctl_dq_oe), .dev_dq_oe(lnk.dev_dq_oe));
	// System clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Accepted write words per bank, and faults on the second link
	always @(posedge mclk) begin
		if (wr_acc === 1'b1) wcnt[wr_bank]++;
		if (cerr2 === 1'b1) seen2 <= 1'b1;
	end
	task automatic summarize();
		if (errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	task automatic ck(input logic [35:0] got, input logic [35:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : ck
	// One request; held until taken, refusal judged
	task automatic go(input logic [3:0] c, input logic [1:0] b,
		input logic a, input logic k, input logic e);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_bank <= b;
		req_ap <= a;
		req_cke <= k;
		req_wdata <= {b, 6'h05};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (req_ready !== 1'b1 && n < 100);
		ck(req_ready, 1'b1);
		ck(req_err, e);
		req_valid <= 1'b0;
		@(posedge mclk);
	endtask : go
	// Let link clocks pass, then settle past registration
	task automatic lw(input int k);
		repeat (k) @(posedge lnk.sd_clk);
		repeat (7) @(posedge mclk);
	endtask : lw
	task automatic t_alt();
		go(CMD_ACT, 2'h0, 1'b0, 1'b1, 1'b0);
		go(CMD_ACT, 2'h1, 1'b0, 1'b1, 1'b0);
		lw(1);
		ck(bank_state[8:0], BK_ACTIVE);
		ck(bank_state[17:9], BK_ACTIVE);
	endtask : t_alt
	task automatic t_rdap();
		go(CMD_RD, 2'h0, 1'b1, 1'b1, 1'b0);
		go(CMD_RD, 2'h1, 1'b0, 1'b1, 1'b0);
		lw(1);
		ck(bank_state[8:0], BK_IDLE);
		ck(bank_state[17:9], BK_READ);
		n = 0;
		while (!(lnk.dev_dq_oe === 1'b1 && lnk.dq[7:6] === 2'h1) && n < 90) begin
			@(posedge mclk);
			n++;
		end
		ck(n < 90, 1'b1);
		lw(4);
	endtask : t_rdap
	task automatic t_pre();
		go(CMD_ACT, 2'h0, 1'b0, 1'b1, 1'b0);
		lw(2);
		go(CMD_RD, 2'h1, 1'b0, 1'b1, 1'b0);
		go(CMD_PRE, 2'h0, 1'b0, 1'b1, 1'b0);
		lw(1);
		ck(bank_state[8:0], BK_IDLE);
		ck(bank_state[17:9], BK_READ);
		lw(5);
	endtask : t_pre
	task automatic t_wrap();
		go(CMD_ACT, 2'h0, 1'b0, 1'b1, 1'b0);
		lw(2);
		wcnt = '{0, 0, 0, 0};
		go(CMD_WR, 2'h0, 1'b1, 1'b1, 1'b0);
		go(CMD_WR, 2'h1, 1'b0, 1'b1, 1'b0);
		lw(7);
		ck(wcnt[0], 1);
		ck(wcnt[1], BURST_LEN);
		ck(bank_state[8:0], BK_IDLE);
		ck(bank_state[17:9], BK_ACTIVE);
	endtask : t_wrap
	task automatic t_refuse();
		go(CMD_REF, 2'h0, 1'b0, 1'b1, 1'b1);
		go(CMD_BST, 2'h2, 1'b0, 1'b1, 1'b1);
		go(CMD_PRE, 2'h1, 1'b0, 1'b1, 1'b0);
		lw(1);
	endtask : t_refuse
	task automatic t_pdown();
		go(CMD_NOP, 2'h0, 1'b0, 1'b0, 1'b0);
		lw(1);
		ck(power_state, PW_PDOWN);
		go(CMD_INH, 2'h0, 1'b0, 1'b0, 1'b0);
		lw(1);
		ck(power_state, PW_PDOWN);
		go(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0);
		go(CMD_ACT, 2'h2, 1'b0, 1'b1, 1'b0);
		lw(2);
		ck(power_state, PW_RUN);
		ck(bank_state[26:18], BK_ACTIVE);
		go(CMD_PRE, 2'h2, 1'b0, 1'b1, 1'b0);
		lw(2);
	endtask : t_pdown
	task automatic t_sref();
		go(CMD_REF, 2'h0, 1'b0, 1'b0, 1'b0);
		lw(1);
		ck(power_state, PW_SREF);
		go(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0);
		repeat (12) @(posedge mclk);
		ck(power_state, PW_SREX);
		go(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0);
		go(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0);
		lw(1);
		ck(power_state, PW_RUN);
	endtask : t_sref
	task automatic t_susp();
		go(CMD_ACT, 2'h3, 1'b0, 1'b1, 1'b0);
		lw(2);
		go(CMD_RD, 2'h3, 1'b0, 1'b1, 1'b0);
		go(CMD_NOP, 2'h0, 1'b0, 1'b0, 1'b0);
		lw(1);
		ck(power_state, PW_SUSP);
		go(CMD_NOP, 2'h0, 1'b0, 1'b1, 1'b0);
		lw(1);
		ck(power_state, PW_RUN);
		ck(bank_state[35:27], BK_READ);
		lw(6);
	endtask : t_susp
	// Bench-made link frame on the second link
	task automatic p2(input logic [3:0] c, input logic k, input logic e);
		seen2 <= 1'b0;
		{lnk2.cs_n, lnk2.ras_n, lnk2.cas_n, lnk2.we_n} <= c;
		lnk2.cke <= k;
		repeat (8) @(posedge mclk);
		lnk2.sd_clk <= 1'b1;
		repeat (8) @(posedge mclk);
		lnk2.sd_clk <= 1'b0;
		ck(seen2, e);
	endtask : p2
	// Main sequence
	initial begin
		reset_n = 1'b0;
		req_valid = 1'b0;
		req_cmd = CMD_NOP;
		req_bank = 2'h0;
		req_ap = 1'b0;
		req_cke = 1'b1;
		req_wdata = 8'h00;
		seen2 = 1'b0;
		{lnk2.sd_clk, lnk2.cke, lnk2.cs_n, lnk2.ras_n} = 4'h7;
		{lnk2.cas_n, lnk2.we_n, lnk2.ba, lnk2.ap} = 5'h18;
		{lnk2.dqm, lnk2.ctl_dq_o, lnk2.ctl_dq_oe} = 10'h000;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_alt();
		t_rdap();
		t_pre();
		t_wrap();
		t_refuse();
		t_pdown();
		t_sref();
		t_susp();
		p2(CMD_BST, 1'b1, 1'b1);
		p2(CMD_NOP, 1'b0, 1'b0);
		p2(CMD_ACT, 1'b1, 1'b1);
		summarize();
	end
	// Watchdog against a hang
	initial begin
		#300000;
		errors++;
		summarize();
	end
endmodule : sdram_bank_cke_command_fsm_tb
